/* File: hw/capture_buffer_defs.svh */
// constants for the capture buffer and delay control block
`ifndef CAPTURE_BUFFER_DEFS_SVH
`define CAPTURE_BUFFER_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_ACC_EN    8'hA8
`define ADDR_DLY       8'hA9
`define ADDR_OVW       8'hAA
`define ADDR_SYS       8'hAB
`define ADDR_LATCMD    8'hAC
`define ADDR_TEST      8'hAD
`define ADDR_PORT      8'hAE
`define ADDR_CAP_BASE  8'h90
`define ADDR_HOLD_BASE 8'hB8
`define ADDR_PACH_BASE 8'hB2
`define ADDR_PAC_BASE  8'hC0

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define SYS_LATCH_QUEUE_SELECT       0
`define SYS_CAPTURE_BUFFER_ENABLE      1
`define SYS_ACCUM_SATURATE      2
`define SYS_FLAG_SETTING_MODE      3
`define SYS_SH_LSB     4
`define LATCMD_FORCE   4
`define TEST_BYPASS    0
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000

// ---------------------------------------------------------------
// delay filter counts in module clocks
// ---------------------------------------------------------------
`define DLY_256        11'h100
`define DLY_512        11'h200
`define DLY_1024       11'h400

`endif

/* File: hw/capture_buffer_pkg.sv */
// types shared by the capture buffer block
package capture_buffer_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_bus_t;

   typedef enum logic {
      FILT_IDLE = 1'b0,
      FILT_WAIT = 1'b1
   } filt_state_t;
endpackage

/* File: hw/capture_buffer_delay_control.sv */
// capture buffering, delay filter, sharing and byte accumulators
`timescale 1ns/100ps
`include "capture_buffer_defs.svh"
module capture_buffer_delay_control (
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   input  wire capture_buffer_pkg::reg_bus_t  regBus,
   output logic [7:0]                         rdData,
   input  wire logic [7:0]                    timerPortPin,
   input  wire logic                          specialModeSelect,
   input  wire logic                          prescaleTick,
   input  wire logic                          modulusZero,
   input  wire logic                          modulusZeroWrite,
   output logic [15:0]                        mainFreeCounter,
   output logic                               timerOverflowFlag,
   output logic [7:0]                         captureChannelFlag,
   output logic [7:0]                         timerPortData
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  accEnReg;
   logic [7:0]  dlyReg;
   logic [7:0]  ovwReg;
   logic [7:0]  sysReg;
   logic [7:0]  testReg;
   logic [7:0]  portReg;
   logic        sysWrittenReg;
   logic [7:0]  pinPrevReg;
   logic [7:0]  filtLevelReg;
   logic [10:0] filtCntReg [8];
   capture_buffer_pkg::filt_state_t filtStateReg [8];
   logic [15:0] capReg [8];
   logic [7:0]  capFullReg;
   logic [15:0] holdReg [4];
   logic [3:0]  holdFullReg;
   logic [7:0]  pacReg [4];
   logic [7:0]  pacHoldReg [4];
   logic [7:0]  flagReg;
   logic [15:0] countReg;
   logic        tofReg;
   logic [7:0]  rdDataReg;

   logic [7:0]  edgeSeen;
   logic [7:0]  filtered;
   logic [7:0]  chanEvent;
   logic [7:0]  capLoad;
   logic [3:0]  holdLoad;
   logic [7:0]  flagSet;
   logic [7:0]  capRd;
   logic [3:0]  holdRd;
   logic [7:0]  rdNext;
   logic [1:0]  dlySel;
   logic [10:0] dlyLimit;
   logic        capture_buffer_enable;
   logic        queueMode;
   logic        latchMode;
   logic        forceLatch;
   logic        latchEvt;
   logic        bypass;
   logic        tofNext;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] offsetAddr(input logic [7:0] base, input int idx);
      offsetAddr = base + idx[7:0];
   endfunction

   function automatic logic [10:0] delayLimit(input logic [1:0] sel);
      case (sel)
         2'b01:   delayLimit = `DLY_256;
         2'b10:   delayLimit = `DLY_512;
         default: delayLimit = `DLY_1024;
      endcase
   endfunction

   // mode decode
   assign dlySel     = dlyReg[1:0];
   assign dlyLimit   = delayLimit(dlySel);
   assign capture_buffer_enable      = sysReg[`SYS_CAPTURE_BUFFER_ENABLE];
   assign queueMode  = capture_buffer_enable && !sysReg[`SYS_LATCH_QUEUE_SELECT];
   assign latchMode  = capture_buffer_enable && sysReg[`SYS_LATCH_QUEUE_SELECT];
   assign bypass     = testReg[`TEST_BYPASS];
   assign forceLatch = regBus.wr && regBus.addr == `ADDR_LATCMD
                       && regBus.wdata[`LATCMD_FORCE];
   assign latchEvt   = latchMode && (modulusZero || modulusZeroWrite || forceLatch);

   // outputs
   assign rdData             = rdDataReg;
   assign mainFreeCounter    = countReg;
   assign timerOverflowFlag  = tofReg;
   assign captureChannelFlag = flagReg;
   assign timerPortData      = portReg;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // software-written control registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         accEnReg      <= `RST_BYTE;
         dlyReg        <= `RST_BYTE;
         ovwReg        <= `RST_BYTE;
         sysReg        <= `RST_BYTE;
         testReg       <= `RST_BYTE;
         portReg       <= `RST_BYTE;
         sysWrittenReg <= 1'b0;
      end else if (regBus.wr) begin
         case (regBus.addr)
            `ADDR_ACC_EN: accEnReg <= {4'h0, regBus.wdata[3:0]};
            `ADDR_DLY:    dlyReg <= {6'h00, regBus.wdata[1:0]};
            `ADDR_OVW:    ovwReg <= regBus.wdata;
            `ADDR_SYS: begin
               if (specialModeSelect || !sysWrittenReg) begin
                  sysReg <= regBus.wdata;
               end
               sysWrittenReg <= 1'b1;
            end
            `ADDR_TEST: begin
               if (specialModeSelect) begin
                  testReg <= {7'h00, regBus.wdata[0]};
               end
            end
            `ADDR_PORT:   portReg <= regBus.wdata;
            default:      accEnReg <= accEnReg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // delay filter
   // ------------------------------------------------------------
   // edge detect and filter output
   always_comb begin
      edgeSeen = timerPortPin ^ pinPrevReg;
      for (int i = 0; i < 8; i++) begin
         if (dlySel == 2'b00) begin
            filtered[i] = edgeSeen[i];
         end else begin
            filtered[i] = filtStateReg[i] == capture_buffer_pkg::FILT_WAIT
                          && filtCntReg[i] >= dlyLimit
                          && timerPortPin[i] != filtLevelReg[i];
         end
      end
   end

   // per-channel delay counter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pinPrevReg   <= `RST_BYTE;
         filtLevelReg <= `RST_BYTE;
         for (int i = 0; i < 8; i++) begin
            filtStateReg[i] <= capture_buffer_pkg::FILT_IDLE;
            filtCntReg[i]   <= 11'h000;
         end
      end else begin
         pinPrevReg <= timerPortPin;
         for (int i = 0; i < 8; i++) begin
            case (filtStateReg[i])
               capture_buffer_pkg::FILT_IDLE: begin
                  if (dlySel != 2'b00 && edgeSeen[i]) begin
                     filtStateReg[i] <= capture_buffer_pkg::FILT_WAIT;
                     filtLevelReg[i] <= pinPrevReg[i];
                     filtCntReg[i]   <= 11'h001;
                  end
               end
               capture_buffer_pkg::FILT_WAIT: begin
                  if (dlySel == 2'b00 || filtCntReg[i] >= dlyLimit) begin
                     filtStateReg[i] <= capture_buffer_pkg::FILT_IDLE;
                     filtCntReg[i]   <= 11'h000;
                  end else begin
                     filtCntReg[i] <= filtCntReg[i] + 11'h001;
                  end
               end
               default: filtStateReg[i] <= capture_buffer_pkg::FILT_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // capture and holding decisions
   // ------------------------------------------------------------
   // sharing, empty tracking and load decisions
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         chanEvent[i] = filtered[i];
         capRd[i] = regBus.rd && regBus.addr == offsetAddr(`ADDR_CAP_BASE, 2 * i + 1);
      end
      for (int i = 4; i < 8; i++) begin
         if (sysReg[`SYS_SH_LSB + i - 4]) begin
            chanEvent[i] = filtered[i - 4];
         end
      end
      for (int i = 0; i < 8; i++) begin
         capLoad[i] = chanEvent[i] && (!ovwReg[i] || !capFullReg[i]);
         flagSet[i] = chanEvent[i];
      end
      for (int i = 0; i < 4; i++) begin
         holdRd[i] = regBus.rd && regBus.addr == offsetAddr(`ADDR_HOLD_BASE, 2 * i + 1);
         holdLoad[i] = 1'b0;
         if (queueMode) begin
            holdLoad[i] = chanEvent[i] && capFullReg[i]
                          && (!ovwReg[i] || !holdFullReg[i]);
            capLoad[i]  = chanEvent[i]
                          && (!capFullReg[i] || holdLoad[i] || !ovwReg[i]);
            if (sysReg[`SYS_FLAG_SETTING_MODE]) begin
               flagSet[i] = holdLoad[i];
            end
         end else if (latchMode) begin
            holdLoad[i] = latchEvt && (!ovwReg[i] || !holdFullReg[i]);
         end
      end
   end

   // capture registers take the main counter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         capFullReg <= `RST_BYTE;
         for (int i = 0; i < 8; i++) begin
            capReg[i] <= `RST_WORD;
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (capLoad[i]) begin
               capReg[i]     <= countReg;
               capFullReg[i] <= 1'b1;
            end else if (capRd[i] || (i < 4 && holdLoad[i % 4])) begin
               capFullReg[i] <= 1'b0;
            end
         end
      end
   end

   // holding registers, capture and accumulator copies
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         holdFullReg <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            holdReg[i]    <= `RST_WORD;
            pacHoldReg[i] <= `RST_BYTE;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (holdLoad[i]) begin
               holdReg[i]     <= capReg[i];
               holdFullReg[i] <= 1'b1;
               if (latchEvt) begin
                  pacHoldReg[i] <= pacReg[i];
               end
            end else if (holdRd[i]) begin
               holdFullReg[i] <= 1'b0;
            end
         end
      end
   end

   // byte accumulators on the filtered channel edges
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) begin
            pacReg[i] <= `RST_BYTE;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (latchEvt) begin
               pacReg[i] <= `RST_BYTE;
            end else if (accEnReg[i] && filtered[i]) begin
               if (!(sysReg[`SYS_ACCUM_SATURATE] && pacReg[i] == 8'hFF)) begin
                  pacReg[i] <= pacReg[i] + 8'h01;
               end
            end
         end
      end
   end

   // registered flag pulses
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flagReg <= `RST_BYTE;
      end else begin
         flagReg <= flagSet;
      end
   end

   // ------------------------------------------------------------
   // main counter with test bypass
   // ------------------------------------------------------------
   // overflow: high byte wrap in bypass, full wrap otherwise
   always_comb begin
      if (bypass) begin
         tofNext = countReg[15:8] == 8'hFF;
      end else begin
         tofNext = prescaleTick && countReg == 16'hFFFF;
      end
   end

   // halves run every clock in bypass
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         countReg <= `RST_WORD;
         tofReg   <= 1'b0;
      end else begin
         tofReg <= tofNext;
         if (bypass) begin
            countReg <= {countReg[15:8] + 8'h01, countReg[7:0] + 8'h01};
         end else if (prescaleTick) begin
            countReg <= countReg + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // read mux, unmapped addresses give zero
   always_comb begin
      case (regBus.addr)
         `ADDR_ACC_EN: rdNext = accEnReg;
         `ADDR_DLY:    rdNext = dlyReg;
         `ADDR_OVW:    rdNext = ovwReg;
         `ADDR_SYS:    rdNext = sysReg;
         `ADDR_LATCMD: rdNext = 8'h00;
         `ADDR_TEST:   rdNext = testReg;
         `ADDR_PORT:   rdNext = timerPortPin;
         default:      rdNext = 8'h00;
      endcase
      for (int i = 0; i < 8; i++) begin
         if (regBus.addr == offsetAddr(`ADDR_CAP_BASE, 2 * i)) begin
            rdNext = capReg[i][15:8];
         end
         if (regBus.addr == offsetAddr(`ADDR_CAP_BASE, 2 * i + 1)) begin
            rdNext = capReg[i][7:0];
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (regBus.addr == offsetAddr(`ADDR_HOLD_BASE, 2 * i)) begin
            rdNext = holdReg[i][15:8];
         end
         if (regBus.addr == offsetAddr(`ADDR_HOLD_BASE, 2 * i + 1)) begin
            rdNext = holdReg[i][7:0];
         end
         if (regBus.addr == offsetAddr(`ADDR_PACH_BASE, 3 - i)) begin
            rdNext = pacHoldReg[i];
         end
         if (regBus.addr == offsetAddr(`ADDR_PAC_BASE, i)) begin
            rdNext = pacReg[i];
         end
      end
   end

   // data stand one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdDataReg <= `RST_BYTE;
      end else begin
         rdDataReg <= regBus.rd ? rdNext : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_sys_write_once: assert property (
      !specialModeSelect && sysWrittenReg && regBus.wr && regBus.addr == `ADDR_SYS
      |=> $stable(sysReg)) else $error("system control rewritten in normal mode");
   a_test_write_guard: assert property (
      !specialModeSelect |=> $stable(testReg))
      else $error("test register changed outside special mode");
   a_accum_disabled: assert property (
      !accEnReg[0] && !latchEvt |=> $stable(pacReg[0]))
      else $error("disabled accumulator counted");
   a_accum_saturate: assert property (
      sysReg[`SYS_ACCUM_SATURATE] && pacReg[0] == 8'hFF && !latchEvt |=> pacReg[0] == 8'hFF)
      else $error("saturated accumulator moved");
   a_force_reads_zero: assert property (
      regBus.rd && regBus.addr == `ADDR_LATCMD |=> rdData == 8'h00)
      else $error("force latch bit read nonzero");
   a_filter_delay_exact: assert property (
      dlySel == 2'b01 && filtered[0] |-> filtCntReg[0] == 11'h100)
      else $error("filter pulse at wrong count");
   a_filter_self_clear: assert property (
      filtStateReg[0] == capture_buffer_pkg::FILT_WAIT && filtCntReg[0] >= dlyLimit
      |=> filtCntReg[0] == 11'h000) else $error("delay counter not cleared");
   a_latch_clears_acc: assert property (
      latchEvt |=> pacReg[0] == 8'h00 && pacReg[3] == 8'h00)
      else $error("accumulator not cleared by latch");
   a_bypass_overflow: assert property (
      bypass && countReg[15:8] == 8'hFF |=> timerOverflowFlag)
      else $error("bypass overflow missed");
   a_queue_flag_hold: assert property (
      queueMode && sysReg[`SYS_FLAG_SETTING_MODE] && !holdLoad[0] |=> !captureChannelFlag[0])
      else $error("queue flag without holding load");
   a_share_route: assert property (
      sysReg[4] && filtered[0] |-> chanEvent[4])
      else $error("shared channel not driven");

   c_queue_move: cover property (queueMode && holdLoad[1]);
   c_latch_event: cover property (latchEvt ##1 holdFullReg[0]);
   c_filter_pulse: cover property (dlySel != 2'b00 && filtered[2]);
endmodule

/* File: verif/pin_source.sv */
// external edge source model driving the timer port pins
`timescale 1ns/100ps
module pin_source (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   output logic [7:0]      pins
);
   int cyc;
   int edgeCyc;

   // free-running cycle count, used to time edges and flag pulses
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) cyc <= 0;
      else cyc <= cyc + 1;
   end

   initial pins = 8'h00;

   // flip one pin just after an edge, then hold the level for the spacing asked, but never fewer than 3 clocks
   task automatic toggle(input int ch, input int gap);
      @(posedge ref_clk);
      pins[ch] <= ~pins[ch];
      edgeCyc = cyc;
      repeat ((gap < 3) ? 3 : gap) @(posedge ref_clk);
   endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the capture buffer and delay control block
`timescale 1ns/100ps
module tb;
   logic                         ref_clk;
   logic                         rstn;
   capture_buffer_pkg::reg_bus_t regBus;
   logic [7:0]                   rdData;
   logic [7:0]                   pins;
   logic                         specialModeSelect;
   logic                         prescaleTick;
   logic                         modulusZero;
   logic                         modulusZeroWrite;
   logic [15:0]                  mainFreeCounter;
   logic                         timerOverflowFlag;
   logic [7:0]                   captureChannelFlag;
   logic [7:0]                   timerPortData;
   logic [7:0]                   flagSeen;
   int                           flagCyc [8];
   int                           fails;
   int                           n_checks;

   capture_buffer_delay_control u_dut (
      .ref_clk(ref_clk), .rstn(rstn), .regBus(regBus), .rdData(rdData),
      .timerPortPin(pins), .specialModeSelect(specialModeSelect),
      .prescaleTick(prescaleTick), .modulusZero(modulusZero),
      .modulusZeroWrite(modulusZeroWrite), .mainFreeCounter(mainFreeCounter),
      .timerOverflowFlag(timerOverflowFlag), .captureChannelFlag(captureChannelFlag),
      .timerPortData(timerPortData));

   pin_source u_src (.ref_clk(ref_clk), .rstn(rstn), .pins(pins));

   // ---------------------------------------------------------------
   // clock, flag monitor and helpers
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // remember which flags pulsed and when
   always @(posedge ref_clk) begin
      for (int i = 0; i < 8; i++) begin
         if (captureChannelFlag[i] === 1'b1) begin
            flagSeen[i] <= 1'b1;
            flagCyc[i] <= u_src.cyc;
         end
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regBus.addr <= a;
      regBus.wdata <= d;
      regBus.wr <= 1'b1;
      @(posedge ref_clk);
      regBus.wr <= 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      regBus.addr <= a;
      regBus.rd <= 1'b1;
      @(posedge ref_clk);
      regBus.rd <= 1'b0;
      #1 d = {8'h00, rdData};
   endtask

   // high byte first: the low byte read empties the register
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      logic [15:0] h;
      logic [15:0] l;
      rd8(a, h);
      rd8(a + 8'h01, l);
      d = {h[7:0], l[7:0]};
   endtask

   task automatic pulse(input int which);
      @(posedge ref_clk);
      if (which == 0) modulusZero <= 1'b1;
      else modulusZeroWrite <= 1'b1;
      @(posedge ref_clk);
      modulusZero <= 1'b0;
      modulusZeroWrite <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      logic [15:0] d;
      rd8(8'hAA, d); chk("overwrite ctl reset", 16'h0000, d);
      rd8(8'hAB, d); chk("system ctl reset", 16'h0000, d);
      rd8(8'h00, d); chk("unmapped read", 16'h0000, d);
      bw(8'hAE, 8'hA5);
      @(posedge ref_clk);
      #1 chk("port latch", 16'h00A5, {8'h00, timerPortData});
      // counter and source cycle count both advance once per edge out of reset
      chk("main counter", 16'(u_src.cyc), mainFreeCounter);
      rd8(8'hAE, d); chk("port pins", 16'h0000, d);
      $display("test regs done");
   endtask

   task automatic t_sys_once();
      logic [15:0] d;
      bw(8'hAB, 8'h02);
      bw(8'hAB, 8'h55);
      rd8(8'hAB, d); chk("system ctl once", 16'h0002, d);
      bw(8'hAD, 8'h01);
      rd8(8'hAD, d); chk("test reg normal", 16'h0000, d);
      @(posedge ref_clk);
      specialModeSelect <= 1'b1;
      bw(8'hAB, 8'h10);
      rd8(8'hAB, d); chk("system ctl special", 16'h0010, d);
      $display("test sys_once done");
   endtask

   task automatic t_share();
      logic [15:0] c0;
      logic [15:0] c4;
      flagSeen = 8'h00;
      u_src.toggle(0, 20);
      chk("flag mode zero", 16'h0011, {8'h00, flagSeen & 8'h11});
      rd16(8'h90, c0);
      rd16(8'h98, c4);
      // capture takes the counter one edge after the pin moved
      chk("own capture", 16'(u_src.edgeCyc + 1), c0);
      chk("shared capture", 16'(u_src.edgeCyc + 1), c4);
      rd16(8'hB8, c0); chk("holding off", 16'h0000, c0);
      $display("test share done");
   endtask

   task automatic t_queue();
      int e1;
      int e0;
      logic [15:0] h;
      logic [15:0] c;
      bw(8'hAB, 8'h0A);
      bw(8'hAA, 8'h01);
      flagSeen = 8'h00;
      u_src.toggle(0, 20);
      e1 = u_src.edgeCyc;
      e0 = e1 + 1;
      chk("queue first no flag", 16'h0000, {15'h0, flagSeen[0]});
      u_src.toggle(0, 20);
      chk("queue second flag", 16'h0001, {15'h0, flagSeen[0]});
      e1 = u_src.edgeCyc - e1;
      u_src.toggle(0, 20);
      rd16(8'hB8, h);
      rd16(8'h90, c);
      chk("queue spacing", 16'(e1), c - h);
      chk("queue holding kept", 16'(e0), h);
      $display("test queue done");
   endtask

   task automatic t_delay();
      int lb;
      int n;
      bw(8'hAB, 8'h00);
      flagSeen = 8'h00;
      u_src.toggle(1, 20);
      lb = flagCyc[1] - u_src.edgeCyc;
      for (int s = 1; s < 4; s++) begin
         n = 256 << (s - 1);
         bw(8'hA9, 8'(s));
         flagSeen = 8'h00;
         u_src.toggle(1, n + 20);
         chk("delay flag", 16'h0001, {15'h0, flagSeen[1]});
         chk("delay length", 16'(lb + n), 16'(flagCyc[1] - u_src.edgeCyc));
      end
      bw(8'hA9, 8'h01);
      flagSeen = 8'h00;
      u_src.toggle(1, 10);
      u_src.toggle(1, 300);
      chk("narrow pulse", 16'h0000, {15'h0, flagSeen[1]});
      bw(8'hA9, 8'h00);
      $display("test delay done");
   endtask

   task automatic t_latch();
      logic [15:0] d;
      bw(8'hAA, 8'h00);
      bw(8'hAB, 8'h0B);
      bw(8'hA8, 8'h01);
      flagSeen = 8'h00;
      repeat (3) u_src.toggle(0, 5);
      chk("latch mode flag", 16'h0001, {15'h0, flagSeen[0]});
      u_src.toggle(1, 5);
      rd8(8'hC0, d); chk("accum count", 16'h0003, d);
      rd8(8'hC1, d); chk("accum disabled", 16'h0000, d);
      pulse(0);
      rd8(8'hB5, d); chk("latch on zero", 16'h0003, d);
      rd8(8'hC0, d); chk("accum cleared", 16'h0000, d);
      repeat (2) u_src.toggle(0, 5);
      bw(8'hAC, 8'h10);
      rd8(8'hB5, d); chk("force latch", 16'h0002, d);
      rd8(8'hAC, d); chk("force reads zero", 16'h0000, d);
      u_src.toggle(0, 5);
      pulse(1);
      rd8(8'hB5, d); chk("latch on zero write", 16'h0001, d);
      bw(8'hAB, 8'h07);
      repeat (257) u_src.toggle(0, 3);
      rd8(8'hC0, d); chk("accum saturate", 16'h00FF, d);
      bw(8'hAB, 8'h03);
      pulse(0);
      repeat (257) u_src.toggle(0, 3);
      rd8(8'hC0, d); chk("accum wrap", 16'h0001, d);
      $display("test latch done");
   endtask

   task automatic t_bypass();
      logic [15:0] d;
      int t1;
      bw(8'hAD, 8'h01);
      // no prescaler ticks: bypass must run the halves on the clock alone
      prescaleTick <= 1'b0;
      rd8(8'hAD, d); chk("test reg special", 16'h0001, d);
      for (int r = 0; r < 2; r++) begin
         if (r == 1) @(posedge ref_clk) #1;
         for (int i = 0; i < 600 && timerOverflowFlag !== 1'b1; i++) @(posedge ref_clk) #1;
         if (r == 0) t1 = u_src.cyc;
      end
      chk("bypass overflow period", 16'd256, 16'(u_src.cyc - t1));
      $display("test bypass done");
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      regBus = '0;
      specialModeSelect = 1'b0;
      prescaleTick = 1'b1;
      modulusZero = 1'b0;
      modulusZeroWrite = 1'b0;
      flagSeen = 8'h00;
      fails = 0;
      n_checks = 0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_sys_once();
      t_share();
      t_queue();
      t_delay();
      t_latch();
      t_bypass();
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      report_and_stop();
   end
endmodule
